// [hdl/fccf_pkg.sv]
// constants, frame layout and types of the card command front end
// assumes one card clock shared by all files of the block
package fccf_pkg;
    localparam int FRAME_BITS = 48;
    localparam int CRC_SPAN = 40;
    localparam logic [5:0] LAST_BIT = 6'h2f;
    localparam logic [5:0] CRC_LAST = 6'h27;
    // positions inside the assembled 48-bit frame
    localparam int POS_START = 47;
    localparam int POS_DIR = 46;
    localparam int POS_IDX_HI = 45;
    localparam int POS_IDX_LO = 40;
    localparam int POS_ARG_HI = 39;
    localparam int POS_ARG_LO = 8;
    localparam int POS_CRC_HI = 7;
    localparam int POS_CRC_LO = 1;
    localparam int POS_END = 0;
    localparam logic [6:0] CRC_POLY = 7'h09;
    localparam logic [6:0] CRC_INIT = 7'h00;
    // command indices with their own effect
    localparam logic [5:0] CMD_IDLE = 6'h00;
    localparam logic [5:0] CMD_SET_ADDR = 6'h03;
    localparam logic [5:0] CMD_SELECT = 6'h07;
    localparam logic [5:0] CMD_BLOCKLEN = 6'h10;
    localparam logic [5:0] CMD_WP_SET = 6'h1c;
    localparam logic [5:0] CMD_WP_CLR = 6'h1d;
    localparam logic [5:0] CMD_TAG_SEC_A = 6'h20;
    localparam logic [5:0] CMD_TAG_SEC_B = 6'h21;
    localparam logic [5:0] CMD_UNTAG_SEC = 6'h22;
    localparam logic [5:0] CMD_TAG_GRP_A = 6'h23;
    localparam logic [5:0] CMD_TAG_GRP_B = 6'h24;
    localparam logic [5:0] CMD_UNTAG_GRP = 6'h25;
    localparam logic [5:0] CMD_ERASE = 6'h26;
    // reset values of the card-specific fields
    localparam logic [31:0] BLOCK_LEN_RESET = 32'h0000_0200;
    localparam logic [4:0] SECTOR_SIZE_RESET = 5'h00;
    localparam logic [4:0] GROUP_SIZE_RESET = 5'h0f;
    localparam logic [4:0] WP_GROUP_SIZE_RESET = 5'h01;
    localparam logic [11:0] CLASS_MASK_RESET = 12'h0ff;

    typedef enum logic [1:0] {KIND_BC, KIND_BCR, KIND_AC, KIND_ADTC} fccf_kind_t;

    typedef struct packed {
        logic [5:0] index;
        logic [31:0] argument;
        fccf_kind_t kind;
        logic supported;
    } fccf_cmd_t;

    typedef struct packed {
        logic [4:0] sectorBlocks;
        logic [4:0] groupSectors;
        logic [4:0] wpGroupSectors;
        logic [11:0] supportedClassMask;
    } fccf_csd_t;
endpackage

// [hdl/fccf_frontend.sv]
// card-side command receiver, decoder, erase tags and group write protection
// assumes cmdLine is the raw command pin; rca and cardSelected come from card
// state logic on clk; responses and data are produced by downstream logic
`timescale 1ns/1ps
// Overview of operation
// - card answers only in reaction to a received command, never by itself.
// - data unit is one byte; block length counted in whole bytes.
// - sector is fixed blocks, group fixed sectors, both reported in card data.
// - one tag bit per sector and group, set or cleared by tag commands.
// - erase command erases all tagged units together in one operation.
// - any command other than tag or untag clears every tag bit.
// - one write-protect bit per protection group, set and cleared by commands.
// - accept indices 0-4, 7, 9-13, 15 and 16-18.
// - accept indices 20, 24-27, 28-30, 32-38 and 42.
// - basic class always present; supported classes published as a mask.
// - no answer to broadcast; broadcast-with-response answered by all cards.
// - only addressed card answers; data commands also start a data transfer.
// - frame bits arrive most significant first and are shifted in so.
// - every command frame is exactly 48 bits long.
// - start, direction, 6-bit index, 32-bit argument, 7-bit CRC, end bit.
// - start bit zero and direction bit one mark a host command.
// - the index field is the binary command number, choosing argument meaning.
// - index 0 sends the card back to idle.
// - index 16 stores the argument as block length for later block commands.
module fccf_frontend
    import fccf_pkg::*;
#(
    parameter int NUM_SECTORS = 16,
    parameter int NUM_GROUPS = 4,
    parameter int NUM_WP_GROUPS = 4
)(
    input wire logic clk,
    input wire logic resetn,
    input wire logic cmdLine,
    input wire logic [15:0] rca,
    input wire logic cardSelected,
    output fccf_cmd_t cmdInfo_ff,
    output logic cmdValid_ff,
    output logic respReq_ff,
    output logic dataReq_ff,
    output logic goIdle_ff,
    output logic frameError_ff,
    output logic crcError_ff,
    output logic [31:0] blockLen_ff,
    output logic [NUM_SECTORS-1:0] sectorTag_ff,
    output logic [NUM_GROUPS-1:0] groupTag_ff,
    output logic eraseReq_ff,
    output logic [NUM_SECTORS-1:0] eraseSectors_ff,
    output logic [NUM_GROUPS-1:0] eraseGroups_ff,
    output logic [NUM_WP_GROUPS-1:0] wpBits_ff,
    output fccf_csd_t csdFields_ff
);
    if (NUM_SECTORS < 1 || NUM_SECTORS > 1024 || NUM_GROUPS < 1 || NUM_GROUPS > 1024
        || NUM_WP_GROUPS < 1 || NUM_WP_GROUPS > 1024)
    begin : g_check
        $error("fccf_frontend: unit counts must lie in 1..1024");
    end
    typedef enum {ST_IDLE, ST_RECV} fccf_state_t;
    function automatic logic [6:0] crcStep(input logic [6:0] crc, input logic bitIn);
        logic fb;
        fb = bitIn ^ crc[6];
        crcStep = {crc[5:0], 1'b0} ^ (fb ? CRC_POLY : CRC_INIT);
    endfunction
    function automatic logic isSupported(input logic [5:0] idx);
        case (idx) inside
            [6'h00:6'h04], 6'h07, [6'h09:6'h0d], 6'h0f, [6'h10:6'h12]: isSupported = 1'b1;
            6'h14, [6'h18:6'h1e], [6'h20:6'h26], 6'h2a: isSupported = 1'b1;
            default: isSupported = 1'b0;
        endcase
    endfunction
    function automatic fccf_kind_t cmdKind(input logic [5:0] idx);
        case (idx) inside
            6'h00, 6'h04: cmdKind = KIND_BC;
            6'h01, 6'h02: cmdKind = KIND_BCR;
            6'h0b, 6'h11, 6'h12, 6'h14, [6'h18:6'h1b], 6'h1e, 6'h2a: cmdKind = KIND_ADTC;
            default: cmdKind = KIND_AC;
        endcase
    endfunction
    function automatic logic isTagCmd(input logic [5:0] idx);
        isTagCmd = (idx >= CMD_TAG_SEC_A) && (idx <= CMD_UNTAG_GRP);
    endfunction
    logic cmdSync1_ff;
    logic cmdSync2_ff;
    fccf_state_t state_ff;
    logic [5:0] bitCnt_ff;
    logic [FRAME_BITS-1:0] shift_ff;
    logic [6:0] crc_ff;
    logic cmdBit;
    logic frameLast;
    logic [FRAME_BITS-1:0] nxt_frame;
    logic shapeOk;
    logic crcOk;
    logic frameOk;
    logic [5:0] nxtIdx;
    logic [31:0] nxtArg;
    fccf_kind_t nxtKind;
    logic nxtSup;
    logic addressed;
    logic nxt_resp;
    logic [1023:0] argHit;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cmdSync1_ff <= 1'b1;
            cmdSync2_ff <= 1'b1;
        end
        else
        begin
            cmdSync1_ff <= cmdLine;
            cmdSync2_ff <= cmdSync1_ff;
        end
    end
    assign cmdBit = cmdSync2_ff;
    assign frameLast = (state_ff == ST_RECV) && (bitCnt_ff == LAST_BIT);
    // final bit is taken straight from the synchroniser output cmdBit so the frame closes on bit 48
    assign nxt_frame = {shift_ff[FRAME_BITS-2:0], cmdBit};
    assign shapeOk = !nxt_frame[POS_START] && nxt_frame[POS_DIR] && nxt_frame[POS_END];
    assign crcOk = (nxt_frame[POS_CRC_HI:POS_CRC_LO] == crc_ff);
    assign frameOk = frameLast && shapeOk && crcOk;
    assign nxtIdx = nxt_frame[POS_IDX_HI:POS_IDX_LO];
    assign nxtArg = nxt_frame[POS_ARG_HI:POS_ARG_LO];
    assign nxtKind = cmdKind(nxtIdx);
    assign nxtSup = isSupported(nxtIdx);
    // one-hot unit select; numbers past the unit count fall off the top
    assign argHit = (nxtArg[31:10] == 22'h000000) ? (1024'h1 << nxtArg[9:0]) : '0;

    // cmd7 with address zero deselects every card, so nobody answers
    always_comb
    begin
        case (nxtIdx)
            CMD_SET_ADDR: addressed = 1'b1;
            CMD_SELECT: addressed = (nxtArg[31:16] == rca) && (rca != 16'h0000);
            6'h09, 6'h0a, 6'h0d, 6'h0f: addressed = (nxtArg[31:16] == rca);
            default: addressed = cardSelected;
        endcase
    end
    always_comb
    begin
        case (nxtKind)
            KIND_BC: nxt_resp = 1'b0;
            KIND_BCR: nxt_resp = 1'b1;
            default: nxt_resp = addressed;
        endcase
    end
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_ff <= ST_IDLE;
            bitCnt_ff <= 6'h00;
            shift_ff <= '0;
            crc_ff <= CRC_INIT;
        end
        else
        begin
            case (state_ff)
                ST_IDLE:
                begin
                    if (!cmdBit)
                    begin
                        state_ff <= ST_RECV;
                        bitCnt_ff <= 6'h01;
                        shift_ff <= nxt_frame;
                        crc_ff <= crcStep(CRC_INIT, cmdBit);
                    end
                end
                ST_RECV:
                begin
                    shift_ff <= nxt_frame;
                    bitCnt_ff <= bitCnt_ff + 6'h01;
                    if (bitCnt_ff <= CRC_LAST)
                    begin
                        crc_ff <= crcStep(crc_ff, cmdBit);
                    end
                    if (frameLast)
                    begin
                        state_ff <= ST_IDLE;
                        bitCnt_ff <= 6'h00;
                    end
                end
                default:
                begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // answer strobes exist only one cycle after an accepted frame
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cmdInfo_ff <= '0;
            cmdValid_ff <= 1'b0;
            respReq_ff <= 1'b0;
            dataReq_ff <= 1'b0;
            goIdle_ff <= 1'b0;
            frameError_ff <= 1'b0;
            crcError_ff <= 1'b0;
        end
        else
        begin
            cmdValid_ff <= frameOk;
            respReq_ff <= frameOk && nxtSup && nxt_resp;
            dataReq_ff <= frameOk && nxtSup && addressed && (nxtKind == KIND_ADTC);
            goIdle_ff <= frameOk && (nxtIdx == CMD_IDLE);
            frameError_ff <= frameLast && !shapeOk;
            crcError_ff <= frameLast && shapeOk && !crcOk;
            if (frameOk)
            begin
                cmdInfo_ff <= '{index: nxtIdx, argument: nxtArg, kind: nxtKind, supported: nxtSup};
            end
        end
    end

    // block length is a byte count; the card's own length stands until changed
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            blockLen_ff <= BLOCK_LEN_RESET;
        end
        else if (frameOk && (nxtIdx == CMD_BLOCKLEN))
        begin
            blockLen_ff <= nxtArg;
        end
    end

    // tag argument is the unit number; out-of-range numbers tag nothing
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sectorTag_ff <= '0;
            groupTag_ff <= '0;
            eraseReq_ff <= 1'b0;
            eraseSectors_ff <= '0;
            eraseGroups_ff <= '0;
        end
        else
        begin
            eraseReq_ff <= frameOk && (nxtIdx == CMD_ERASE);
            if (frameOk && (nxtIdx == CMD_ERASE))
            begin
                eraseSectors_ff <= sectorTag_ff;
                eraseGroups_ff <= groupTag_ff;
            end
            if (frameOk && !isTagCmd(nxtIdx))
            begin
                sectorTag_ff <= '0;
                groupTag_ff <= '0;
            end
            else if (frameOk)
            begin
                if (nxtIdx == CMD_TAG_SEC_A || nxtIdx == CMD_TAG_SEC_B)
                begin
                    sectorTag_ff <= sectorTag_ff | argHit[NUM_SECTORS-1:0];
                end
                else if (nxtIdx == CMD_UNTAG_SEC)
                begin
                    sectorTag_ff <= sectorTag_ff & ~argHit[NUM_SECTORS-1:0];
                end
                if (nxtIdx == CMD_TAG_GRP_A || nxtIdx == CMD_TAG_GRP_B)
                begin
                    groupTag_ff <= groupTag_ff | argHit[NUM_GROUPS-1:0];
                end
                else if (nxtIdx == CMD_UNTAG_GRP)
                begin
                    groupTag_ff <= groupTag_ff & ~argHit[NUM_GROUPS-1:0];
                end
            end
        end
    end

    // only the selected card may change its protection bits
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wpBits_ff <= '0;
        end
        else if (frameOk && cardSelected && (nxtIdx == CMD_WP_SET))
        begin
            wpBits_ff <= wpBits_ff | argHit[NUM_WP_GROUPS-1:0];
        end
        else if (frameOk && cardSelected && (nxtIdx == CMD_WP_CLR))
        begin
            wpBits_ff <= wpBits_ff & ~argHit[NUM_WP_GROUPS-1:0];
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            csdFields_ff <= '{sectorBlocks: SECTOR_SIZE_RESET, groupSectors: GROUP_SIZE_RESET,
                              wpGroupSectors: WP_GROUP_SIZE_RESET, supportedClassMask: CLASS_MASK_RESET};
        end
        else
        begin
            csdFields_ff <= csdFields_ff;
        end
    end

    sequence s_start;
        (state_ff == ST_IDLE) && !cmdBit;
    endsequence
    sequence s_close;
        frameLast ##1 (cmdValid_ff || frameError_ff || crcError_ff);
    endsequence
    property p_frame_len;
        @(posedge clk) disable iff (!resetn)
        s_start |-> ##47 s_close;
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame not closed at bit 48");
    property p_resp_cause;
        @(posedge clk) disable iff (!resetn)
        respReq_ff |-> $past(frameOk) && cmdValid_ff && cmdInfo_ff.supported;
    endproperty
    a_resp_cause: assert property (p_resp_cause) else $error("answer without command");
    property p_bad_shape;
        @(posedge clk) disable iff (!resetn)
        frameLast && (!cmdBit || !shift_ff[POS_DIR-1]) |=> frameError_ff && !cmdValid_ff;
    endproperty
    a_bad_shape: assert property (p_bad_shape) else $error("bad frame accepted");
    property p_bad_crc;
        @(posedge clk) disable iff (!resetn)
        frameLast && !crcOk |=> !cmdValid_ff && !respReq_ff;
    endproperty
    a_bad_crc: assert property (p_bad_crc) else $error("bad crc accepted");
    property p_idle;
        @(posedge clk) disable iff (!resetn)
        goIdle_ff == (cmdValid_ff && cmdInfo_ff.index == CMD_IDLE);
    endproperty
    a_idle: assert property (p_idle) else $error("idle strobe wrong");
    property p_blocklen;
        @(posedge clk) disable iff (!resetn)
        cmdValid_ff && cmdInfo_ff.index == CMD_BLOCKLEN |-> blockLen_ff == cmdInfo_ff.argument ##1 $stable(blockLen_ff);
    endproperty
    a_blocklen: assert property (p_blocklen) else $error("block length not stored");
    property p_tag_clear;
        @(posedge clk) disable iff (!resetn)
        cmdValid_ff && !isTagCmd(cmdInfo_ff.index) |-> sectorTag_ff == '0 && groupTag_ff == '0;
    endproperty
    a_tag_clear: assert property (p_tag_clear) else $error("tags survive other command");
    property p_erase_set;
        @(posedge clk) disable iff (!resetn)
        eraseReq_ff |-> eraseSectors_ff == $past(sectorTag_ff) && eraseGroups_ff == $past(groupTag_ff);
    endproperty
    a_erase_set: assert property (p_erase_set) else $error("erase set differs from tags");
    property p_no_bc_resp;
        @(posedge clk) disable iff (!resetn)
        cmdValid_ff && (cmdInfo_ff.kind == KIND_BC || !cmdInfo_ff.supported) |-> !respReq_ff && !dataReq_ff;
    endproperty
    a_no_bc_resp: assert property (p_no_bc_resp) else $error("answer to broadcast or unknown");
    property p_data_kind;
        @(posedge clk) disable iff (!resetn)
        dataReq_ff |-> respReq_ff && cmdInfo_ff.kind == KIND_ADTC;
    endproperty
    a_data_kind: assert property (p_data_kind) else $error("data start on non-data command");
endmodule

// [testbench/fccf_host_model.sv]
// host model: serialises command frames onto the card command pin
// assumes the bench calls sendFrame; the pin idles high between frames
`timescale 1ns/1ps
module fccf_host_model
(
    input wire logic clk,
    output logic cmdLine
);
    // host only speaks when the bench asks it to
    initial cmdLine = 1'b1;
    function automatic logic [6:0] crc7(input logic [39:0] body);
        logic [6:0] c;
        logic fb;
        c = 7'h00;
        for (int i = 39; i >= 0; i--)
        begin
            fb = body[i] ^ c[6];
            c = {c[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
        end
        return c;
    endfunction
    // flaw: [0] bad crc, [1] bad direction bit, [2] bad end bit
    task automatic sendFrame(input logic [5:0] idx, input logic [31:0] arg, input logic [2:0] flaw);
        logic [39:0] body;
        logic [47:0] frame;
        body = {1'b0, ~flaw[1], idx, arg};
        frame = {body, crc7(body) ^ {6'h00, flaw[0]}, ~flaw[2]};
        for (int i = 47; i >= 0; i--)
        begin
            @(negedge clk);
            cmdLine = frame[i];
        end
        @(negedge clk);
        cmdLine = 1'b1;
    endtask
endmodule

// [testbench/fccf_frontend_tb.sv]
// self-checking bench of the card command front end
// assumes the host model drives the command pin at falling clock edges
`timescale 1ns/1ps
module fccf_frontend_tb
    import fccf_pkg::*;
;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic cardSelected = 1'b1;
    logic [15:0] rca = 16'h1234;
    logic cmdLine;
    fccf_cmd_t cmdInfo;
    fccf_csd_t csd;
    logic cmdValid, respReq, dataReq, goIdle, frameErr, crcErr, eraseReq;
    logic [31:0] blockLen;
    logic [15:0] sectorTag, eraseSectors;
    logic [3:0] groupTag, eraseGroups, wpBits;
    logic gotValid, gotFrameErr, gotCrcErr, gotResp, gotData, gotIdle, gotErase;
    int failCount = 0;
    int totalChecks = 0;

    always #4 clk = ~clk;

    fccf_frontend #(.NUM_SECTORS(16), .NUM_GROUPS(4), .NUM_WP_GROUPS(4)) uut (
        .clk(clk), .resetn(resetn), .cmdLine(cmdLine), .rca(rca), .cardSelected(cardSelected),
        .cmdInfo_ff(cmdInfo), .cmdValid_ff(cmdValid), .respReq_ff(respReq), .dataReq_ff(dataReq),
        .goIdle_ff(goIdle), .frameError_ff(frameErr), .crcError_ff(crcErr), .blockLen_ff(blockLen),
        .sectorTag_ff(sectorTag), .groupTag_ff(groupTag), .eraseReq_ff(eraseReq),
        .eraseSectors_ff(eraseSectors), .eraseGroups_ff(eraseGroups), .wpBits_ff(wpBits),
        .csdFields_ff(csd)
    );
    fccf_host_model host (.clk(clk), .cmdLine(cmdLine));

    task automatic conclude();
        $display("checks %0d mismatches %0d", totalChecks, failCount);
        if (failCount == 0 && totalChecks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chkBit(input string name, input logic exp, input logic got);
        totalChecks++;
        if (got !== exp)
        begin
            failCount++;
            $display("MISMATCH %s exp %b got %b", name, exp, got);
        end
    endtask

    task automatic chkVec(input string name, input logic [31:0] exp, input logic [31:0] got);
        totalChecks++;
        if (got !== exp)
        begin
            failCount++;
            $display("MISMATCH %s exp %h got %h", name, exp, got);
        end
    endtask

    function automatic logic supp(input logic [5:0] i);
        return i inside {[0:4], 7, [9:13], [15:18], 20, [24:30], [32:38], 42};
    endfunction

    function automatic fccf_kind_t kindOf(input logic [5:0] i);
        if (i inside {0, 4})
            return KIND_BC;
        if (i inside {1, 2})
            return KIND_BCR;
        if (i inside {11, 17, 18, 20, [24:27], 30, 42})
            return KIND_ADTC;
        return KIND_AC;
    endfunction

    // one frame, then capture the result strobes of that frame
    task automatic cmd(input logic [5:0] idx, input logic [31:0] arg, input logic [2:0] flaw);
        int n;
        host.sendFrame(idx, arg, flaw);
        n = 0;
        while (n < 8 && (cmdValid | frameErr | crcErr) !== 1'b1)
        begin
            @(negedge clk);
            n++;
        end
        if (n == 8)
        begin
            failCount++;
            $display("MISMATCH result exp pulse got none");
            conclude();
        end
        {gotValid, gotFrameErr, gotCrcErr, gotResp, gotData, gotIdle, gotErase} =
            {cmdValid, frameErr, crcErr, respReq, dataReq, goIdle, eraseReq};
        @(negedge clk);
        chkBit("strobeEnd", 1'b0, cmdValid | frameErr | crcErr);
    endtask

    task automatic scnReset();
        chkVec("blockLen", BLOCK_LEN_RESET, blockLen);
        chkVec("csd", {5'h00, 5'h00, 5'h0f, 5'h01, 12'h0ff}, {5'h00, csd});
        chkBit("basicClass", 1'b1, csd.supportedClassMask[0]);
        chkVec("state", 32'h0, {sectorTag, groupTag, wpBits});
    endtask

    task automatic scnIndexSweep();
        for (int i = 0; i < 64; i++)
        begin
            cmd(i[5:0], {rca, 16'h0000}, 3'b000);
            chkBit("cmdValid", 1'b1, gotValid);
            chkVec("index", i, {26'h0, cmdInfo.index});
            chkBit("supported", supp(i[5:0]), cmdInfo.supported);
            chkBit("respReq", supp(i[5:0]) && kindOf(i[5:0]) != KIND_BC, gotResp);
            chkBit("dataReq", supp(i[5:0]) && kindOf(i[5:0]) == KIND_ADTC, gotData);
            chkBit("goIdle", i == 0, gotIdle);
            if (supp(i[5:0]))
                chkVec("kind", kindOf(i[5:0]), {30'h0, cmdInfo.kind});
        end
    endtask

    task automatic scnAddress();
        cardSelected = 1'b0;
        cmd(6'h11, 32'h0, 3'b000);
        chkBit("respReq", 1'b0, gotResp | gotData);
        cmd(6'h02, 32'h0, 3'b000);
        chkBit("respReq", 1'b1, gotResp);
        cmd(6'h1c, 32'h1, 3'b000);
        chkVec("wp", 32'h0, wpBits);
        cardSelected = 1'b1;
        cmd(6'h09, {~rca, 16'h0}, 3'b000);
        chkBit("respReq", 1'b0, gotResp);
        cmd(6'h1c, 32'h2, 3'b000);
        cmd(6'h1c, 32'h0, 3'b000);
        chkVec("wp", 32'h5, wpBits);
        cmd(6'h1d, 32'h2, 3'b000);
        chkVec("wp", 32'h1, wpBits);
    endtask

    task automatic scnBlockLen();
        cmd(6'h10, 32'h0000_0400, 3'b000);
        chkVec("blockLen", 32'h400, blockLen);
        chkVec("argument", 32'h400, cmdInfo.argument);
        // each flawed frame must leave the stored length alone
        for (int f = 0; f < 3; f++)
        begin
            cmd(6'h10, 32'h7, 3'b001 << f);
            chkVec("errFlags", f == 0 ? 32'h1 : 32'h2, {gotValid, gotFrameErr, gotCrcErr});
            chkVec("blockLen", 32'h400, blockLen);
        end
        cmd(6'h10, 32'h1, 3'b000);
        chkVec("blockLen", 32'h1, blockLen);
    endtask

    task automatic scnErase();
        cmd(6'h20, 32'h3, 3'b000);
        cmd(6'h21, 32'h5, 3'b000);
        cmd(6'h22, 32'h5, 3'b000);
        cmd(6'h23, 32'h1, 3'b000);
        cmd(6'h24, 32'h2, 3'b000);
        cmd(6'h25, 32'h2, 3'b000);
        cmd(6'h20, 32'h10, 3'b000);
        chkVec("tags", 32'h00082, {sectorTag, groupTag});
        cmd(6'h26, 32'h0, 3'b000);
        chkBit("eraseReq", 1'b1, gotErase);
        chkVec("eraseSet", 32'h00082, {eraseSectors, eraseGroups});
        chkVec("tags", 32'h0, {sectorTag, groupTag});
        cmd(6'h20, 32'hf, 3'b000);
        cmd(6'h0d, {rca, 16'h0}, 3'b000);
        chkVec("tags", 32'h0, {sectorTag, groupTag});
        cmd(6'h23, 32'h3, 3'b000);
        cmd(6'h05, 32'h0, 3'b000);
        chkVec("tags", 32'h0, {sectorTag, groupTag});
        cmd(6'h20, 32'h0, 3'b000);
        cmd(6'h10, 32'h9, 3'b001);
        cmd(6'h26, 32'h0, 3'b000);
        chkVec("eraseSet", 32'h00010, {eraseSectors, eraseGroups});
    endtask

    initial
    begin
        repeat (20) @(negedge clk);
        resetn = 1'b1;
        @(negedge clk);
        scnReset();
        scnIndexSweep();
        scnAddress();
        scnBlockLen();
        scnErase();
        conclude();
    end
endmodule
